// ### verilog/dtc_pkg.sv
/*
 * dtc_pkg: constants, register map and code tables for the tone codec core.
 * Assumes a single 10 MHz system clock and a 32-bit AHB-Lite register bus.
 */
`default_nettype none
package dtc_pkg;
   localparam int CLK_HZ = 10000000;
   localparam int OSC_HZ = 3579545;
   localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
   // register indices; byte address is four times the index
   localparam logic [31:0] DATA_IDX = 32'h0000_0000;
   localparam logic [31:0] CTRL_IDX = 32'h0000_0001;
   // control bits
   localparam int CTL_TX_EN = 0;
   localparam int CTL_CP_MODE = 1;
   localparam int CTL_IRQ_EN = 2;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   // status bits
   localparam int STS_IRQ = 0;
   localparam int STS_RX_VALID = 2;
   localparam int STS_DELAYED = 3;
   // tone period tolerance in percent of nominal
   localparam int TOL_PCT = 2;
   localparam int SETTLE_NS = 400;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOSS_CYC_DEF = (CLK_HZ / 697) * (100 + TOL_PCT) / 100;
   localparam int SEG_COUNT = 32;
   localparam logic [7:0] SINE_MID = 8'h80;

   typedef enum logic [1:0] {
      DTC_ST_IDLE = 2'b00,
      DTC_ST_SETTLE = 2'b01,
      DTC_ST_VALID = 2'b10
   } dtc_steer_e;

   function automatic int dtc_tone_hz(input logic grp, input logic [1:0] i);
      case ({grp, i})
         3'h0: return 697;
         3'h1: return 770;
         3'h2: return 852;
         3'h3: return 941;
         3'h4: return 1209;
         3'h5: return 1336;
         3'h6: return 1477;
         default: return 1633;
      endcase
   endfunction

   // oscillator ticks per segment: 32 segments per tone period
   function automatic logic [7:0] dtc_seg_len(input logic grp, input logic [1:0] i);
      return 8'((OSC_HZ + SEG_COUNT * dtc_tone_hz(grp, i) / 2) /
                (SEG_COUNT * dtc_tone_hz(grp, i)));
   endfunction

   // returns {match, index} for a measured period in clock cycles
   function automatic logic [2:0] dtc_classify(input logic [15:0] per, input logic grp);
      logic [2:0] r;
      int nom;
      r = 3'h0;
      for (int i = 0; i < 4; i++) begin
         nom = CLK_HZ / dtc_tone_hz(grp, 2'(i));
         if (int'(per) >= nom * (100 - TOL_PCT) / 100 &&
             int'(per) <= nom * (100 + TOL_PCT) / 100) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [3:0] dtc_pair_to_code(input logic [1:0] row, input logic [1:0] col);
      if (col == 2'h3) begin
         return (row == 2'h3) ? 4'h0 : 4'(4'hd + row);
      end
      if (row == 2'h3) begin
         case (col)
            2'h0: return 4'hb;
            2'h1: return 4'ha;
            default: return 4'hc;
         endcase
      end
      return 4'(row * 3 + col + 1);
   endfunction

   // {row, col}; codes outside the table never occur, all 16 map
   function automatic logic [3:0] dtc_code_to_pair(input logic [3:0] code);
      case (code)
         4'h0: return 4'hf;
         4'ha: return 4'hd;
         4'hb: return 4'hc;
         4'hc: return 4'he;
         4'hd: return 4'h3;
         4'he: return 4'h7;
         4'hf: return 4'hb;
         default: return {2'((code - 4'h1) / 4'h3), 2'((code - 4'h1) % 4'h3)};
      endcase
   endfunction

   // 8-bit sine centred on 0x80, from a quarter-wave table
   function automatic logic [7:0] dtc_sine(input logic [4:0] seg);
      logic [3:0] m;
      logic [7:0] a;
      m = (seg[3:0] <= 4'h8) ? seg[3:0] : 4'(5'h10 - {1'b0, seg[3:0]});
      case (m)
         4'h0: a = 8'h00;
         4'h1: a = 8'h19;
         4'h2: a = 8'h31;
         4'h3: a = 8'h47;
         4'h4: a = 8'h5a;
         4'h5: a = 8'h6a;
         4'h6: a = 8'h75;
         4'h7: a = 8'h7d;
         default: a = 8'h7f;
      endcase
      return seg[4] ? 8'(SINE_MID - a) : 8'(SINE_MID + a);
   endfunction
endpackage
`default_nettype wire

// ### verilog/dtc_tone_codec_core.sv
/*
 * dtc_tone_codec_core: digital core of a dual-tone transceiver with an
 * AHB-Lite register slave, tone period decoder, steering logic and a
 * two-chain tone generator.
 * Assumes limited tone inputs synchronous to clk_sys, an external steering
 * RC network whose threshold result arrives on steering_sense, and an
 * external pull-up on the open-drain irq pin.
 */
`default_nettype none
module dtc_tone_codec_core #(
   parameter int LOSS_CYC = dtc_pkg::LOSS_CYC_DEF
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic low_tone_in,
   input wire logic high_tone_in,
   input wire logic progress_in,
   input wire logic steering_sense,
   output logic guard_time_drive,
   output logic guard_time_oe,
   output logic early_pair_detect,
   output logic irq_or_progress_out,
   output logic irq_or_progress_oe,
   output logic [7:0] row_sample,
   output logic [7:0] col_sample,
   output logic [8:0] tone_mix
);
   import dtc_pkg::*;

   logic [3:0] ctrl_reg;
   logic [3:0] tx_code_reg;
   logic [3:0] rx_code_reg;
   logic [3:0] pend_code_reg;
   logic rx_valid_reg;
   logic irq_pend_reg;
   logic delayed_reg;
   logic early_reg;
   logic gt_reg;
   logic gt_oe_reg;
   logic irq_oe_reg;
   logic [31:0] hrdata_reg;
   logic wr_pend_reg;
   logic wr_ctrl_reg;
   logic st_meta_reg;
   logic st_sync_reg;
   logic st_prev_reg;
   dtc_steer_e steer_reg;
   dtc_steer_e steer_next;
   logic [7:0] settle_reg;
   logic [7:0] settle_next;
   logic [23:0] osc_acc_reg;
   logic [7:0] mix_row_reg;
   logic [7:0] mix_col_reg;
   logic [8:0] mix_reg;

   // bus decode
   // unmapped words read as zero and drop writes, the answer stays okay
   wire logic xfer = hsel & htrans[1] & hready;
   wire logic mapped = (haddr[31:3] == 29'h000_0000) && (haddr[1:0] == 2'h0);
   wire logic idx_ctrl = (haddr[2] == CTRL_IDX[0]);
   wire logic rd_go = xfer & ~hwrite & mapped;
   wire logic wr_go = xfer & hwrite & mapped;
   wire logic rd_status = rd_go & idx_ctrl;
   wire logic rd_rxdata = rd_go & ~idx_ctrl;
   wire logic cp_mode = ctrl_reg[CTL_CP_MODE];
   wire logic irq_en = ctrl_reg[CTL_IRQ_EN];
   wire logic tx_en = ctrl_reg[CTL_TX_EN];
   wire logic [3:0] status_word = {delayed_reg, rx_valid_reg, 1'b0, irq_pend_reg};
   wire logic [31:0] rd_word = rd_status ? {28'h000_0000, status_word} :
                               rd_rxdata ? {28'h000_0000, rx_code_reg} : 32'h0000_0000;

   // address phase: capture read data and write target
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hrdata_reg <= 32'h0000_0000;
         wr_pend_reg <= 1'b0;
         wr_ctrl_reg <= 1'b0;
      end else if (hready) begin
         hrdata_reg <= rd_word;
         wr_pend_reg <= wr_go;
         wr_ctrl_reg <= idx_ctrl;
      end
   end

   // data phase writes
   // hwdata only stands in the data phase, so the target is kept from the address phase
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
         tx_code_reg <= 4'h0;
      end else if (wr_pend_reg && wr_ctrl_reg) begin
         ctrl_reg <= hwdata[3:0];
      end else if (wr_pend_reg) begin
         tx_code_reg <= hwdata[3:0];
      end
   end

   // receiver: period measurement per group
   // the count saturates so a dead input never wraps into a false match
   // a period is judged at the rise that closes it, hence two rises per tone
   logic [1:0] tone_ok;
   logic [1:0][1:0] tone_idx;
   wire logic [1:0] tone_in = {high_tone_in, low_tone_in};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_meas
         logic [15:0] cnt_reg;
         logic prev_reg;
         logic [2:0] res_reg;
         wire logic edge_up = tone_in[g] & ~prev_reg;
         wire logic lost = (int'(cnt_reg) >= LOSS_CYC);
         wire logic [2:0] res_now = dtc_classify(cnt_reg, 1'(g));
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               cnt_reg <= 16'h0000;
               prev_reg <= 1'b0;
               res_reg <= 3'h0;
            end else begin
               prev_reg <= tone_in[g];
               if (edge_up) begin
                  cnt_reg <= 16'h0001;
                  res_reg <= res_now;
               end else begin
                  if (cnt_reg != 16'hffff) begin
                     cnt_reg <= cnt_reg + 16'h0001;
                  end
                  if (lost) begin
                     res_reg <= 3'h0;
                  end
               end
            end
         end
         assign tone_ok[g] = res_reg[2];
         assign tone_idx[g] = res_reg[1:0];
      end
   endgenerate

   // no pair detection in call-progress mode
   // early detect is registered, two cycles behind the closing tone edge
   wire logic early_next = tone_ok[0] & tone_ok[1] & ~cp_mode;
   wire logic [3:0] pair_code = dtc_pair_to_code(tone_idx[0], tone_idx[1]);
   wire logic st_rise = st_sync_reg & ~st_prev_reg;
   wire logic registering = (steer_reg == DTC_ST_IDLE) & st_rise & early_reg;
   wire logic delayed_rise = (steer_next == DTC_ST_VALID) & ~delayed_reg;

   // steering state: the external rc sets how long st lags early detect,
   // so short tones never cross and short dropouts never fall below
   always_comb begin
      steer_next = steer_reg;
      settle_next = settle_reg;
      unique case (steer_reg)
         DTC_ST_IDLE: begin
            if (registering) begin
               steer_next = DTC_ST_SETTLE;
               settle_next = 8'(SETTLE_CYC - 1);
            end
         end
         DTC_ST_SETTLE: begin
            if (!st_sync_reg) begin
               steer_next = DTC_ST_IDLE;
            end else if (settle_reg == 8'h00) begin
               steer_next = DTC_ST_VALID;
            end else begin
               settle_next = settle_reg - 8'h01;
            end
         end
         DTC_ST_VALID: begin
            if (!st_sync_reg) begin
               steer_next = DTC_ST_IDLE;
            end
         end
         default: steer_next = DTC_ST_IDLE;
      endcase
   end

   // only the second flop reads the first; the third just finds the rise
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_meta_reg <= 1'b0;
         st_sync_reg <= 1'b0;
         st_prev_reg <= 1'b0;
      end else begin
         st_meta_reg <= steering_sense;
         st_sync_reg <= st_meta_reg;
         st_prev_reg <= st_sync_reg;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         steer_reg <= DTC_ST_IDLE;
         settle_reg <= 8'h00;
         pend_code_reg <= 4'h0;
         delayed_reg <= 1'b0;
         early_reg <= 1'b0;
         gt_reg <= 1'b0;
         gt_oe_reg <= 1'b0;
      end else begin
         steer_reg <= steer_next;
         settle_reg <= settle_next;
         early_reg <= early_next;
         if (registering) begin
            pend_code_reg <= pair_code;
         end
         delayed_reg <= (steer_next == DTC_ST_VALID);
         gt_reg <= early_next & (steer_next != DTC_ST_IDLE);
         gt_oe_reg <= 1'b1;
      end
   end

   // receive latch and sticky flags; a new event wins over the read clear
   // the code waits from registration, so a tone change during settle cannot land
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_code_reg <= 4'h0;
         rx_valid_reg <= 1'b0;
         irq_pend_reg <= 1'b0;
      end else begin
         if (delayed_rise) begin
            rx_code_reg <= pend_code_reg;
         end
         rx_valid_reg <= delayed_rise | (rx_valid_reg & ~rd_status);
         irq_pend_reg <= delayed_rise | (irq_pend_reg & ~rd_status);
      end
   end

   // open drain: enable high pulls the pin low
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_oe_reg <= 1'b0;
      end else if (cp_mode) begin
         irq_oe_reg <= irq_en & ~progress_in;
      end else begin
         irq_oe_reg <= irq_en & irq_pend_reg;
      end
   end

   // generator timebase: fractional accumulator gives the oscillator rate
   // as an average; it never stops so bursts start at once
   wire logic [24:0] osc_sum = {1'b0, osc_acc_reg} + 25'(OSC_HZ);
   wire logic osc_tick = (osc_sum >= 25'(CLK_HZ));
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         osc_acc_reg <= 24'h00_0000;
      end else begin
         osc_acc_reg <= osc_tick ? 24'(osc_sum - 25'(CLK_HZ)) : 24'(osc_sum);
      end
   end

   wire logic [3:0] tx_pair = dtc_code_to_pair(tx_code_reg);
   logic [1:0][7:0] samp;

   generate
      for (g = 0; g < 2; g++) begin : g_gen
         logic [7:0] div_reg;
         logic [4:0] seg_reg;
         logic [7:0] out_reg;
         // chain 0 plays the row, chain 1 the column; only the lookup differs
         // a new code mid-segment may wrap at the next tick: one short segment
         wire logic [1:0] sel = (g == 0) ? tx_pair[3:2] : tx_pair[1:0];
         wire logic [7:0] len = dtc_seg_len(1'(g), sel);
         wire logic div_wrap = osc_tick && (div_reg >= len - 8'h01);
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               div_reg <= 8'h00;
               seg_reg <= 5'h00;
               out_reg <= SINE_MID;
            end else begin
               if (div_wrap) begin
                  div_reg <= 8'h00;
                  seg_reg <= seg_reg + 5'h01;
               end else if (osc_tick) begin
                  div_reg <= div_reg + 8'h01;
               end
               out_reg <= tx_en ? dtc_sine(seg_reg) : SINE_MID;
            end
         end
         assign samp[g] = out_reg;
      end
   endgenerate

   // nine bits: two full-scale samples never overflow the sum
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mix_row_reg <= SINE_MID;
         mix_col_reg <= SINE_MID;
         mix_reg <= 9'h100;
      end else begin
         mix_row_reg <= samp[0];
         mix_col_reg <= samp[1];
         mix_reg <= {1'b0, samp[0]} + {1'b0, samp[1]};
      end
   end

   // zero wait states; word size is not checked, hsize is only read here
   assign hreadyout = 1'b1 | hsize[0];
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign guard_time_drive = gt_reg;
   assign guard_time_oe = gt_oe_reg;
   assign early_pair_detect = early_reg;
   // open-drain data stays low; only the enable moves
   assign irq_or_progress_out = 1'b0;
   assign irq_or_progress_oe = irq_oe_reg;
   assign row_sample = mix_row_reg;
   assign col_sample = mix_col_reg;
   assign tone_mix = mix_reg;
endmodule
`default_nettype wire

// ### sim/dtc_core_props.sv
/*
 * dtc_core_props: port-level checks of dtc_tone_codec_core.
 * Assumes it is bound into the core; one clock, async active-high reset.
 */
`default_nettype none
module dtc_core_props #(
   parameter int LOSS_CYC = dtc_pkg::LOSS_CYC_DEF
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic low_tone_in,
   input wire logic high_tone_in,
   input wire logic steering_sense,
   input wire logic guard_time_drive,
   input wire logic guard_time_oe,
   input wire logic early_pair_detect,
   input wire logic [7:0] row_sample,
   input wire logic [7:0] col_sample,
   input wire logic [8:0] tone_mix
);
   localparam int LO_MIN = dtc_pkg::CLK_HZ / 941 * (100 - dtc_pkg::TOL_PCT) / 100;
   localparam int LO_MAX = dtc_pkg::CLK_HZ / 697 * (100 + dtc_pkg::TOL_PCT) / 100;
   localparam int HI_MIN = dtc_pkg::CLK_HZ / 1633 * (100 - dtc_pkg::TOL_PCT) / 100;
   localparam int HI_MAX = dtc_pkg::CLK_HZ / 1209 * (100 + dtc_pkg::TOL_PCT) / 100;
   logic lo_q, hi_q, in_band, stale;
   logic [15:0] lo_idle, hi_idle, lo_per, hi_per;
   // early detect may also rise when call-progress mode ends, long after
   // a tone edge, so only the last whole periods are judged
   assign in_band = int'(lo_per) >= LO_MIN && int'(lo_per) <= LO_MAX &&
      int'(hi_per) >= HI_MIN && int'(hi_per) <= HI_MAX;
   // margin covers the core's edge detect and output register
   assign stale = lo_idle > 16'(LOSS_CYC + 8) || hi_idle > 16'(LOSS_CYC + 8);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // cycles since each tone's last rise, saturating
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lo_q <= 1'h0;
         hi_q <= 1'h0;
         lo_idle <= 16'hffff;
         hi_idle <= 16'hffff;
         lo_per <= 16'h0000;
         hi_per <= 16'h0000;
      end else begin
         lo_q <= low_tone_in;
         hi_q <= high_tone_in;
         if (low_tone_in && !lo_q) lo_per <= lo_idle + 16'h0001;
         if (high_tone_in && !hi_q) hi_per <= hi_idle + 16'h0001;
         lo_idle <= (low_tone_in && !lo_q) ? 16'h0000 : lo_idle + 16'(lo_idle != 16'hffff);
         hi_idle <= (high_tone_in && !hi_q) ? 16'h0000 : hi_idle + 16'(hi_idle != 16'hffff);
      end
   end
   sequence s_early_gone;
      !early_pair_detect [*2];
   endsequence
   // enabling the generator leaves mid-scale at any phase of a segment
   sequence s_seg_step;
      $changed(col_sample) && $past(col_sample) != 8'h80;
   endsequence
   property p_ok; hreadyout && !hresp; endproperty
   property p_gt_oe; !$past(rst) |-> guard_time_oe; endproperty
   property p_gt_follow; s_early_gone |-> !guard_time_drive; endproperty
   property p_gt_steer; $rose(guard_time_drive) |-> $past(steering_sense, 2); endproperty
   property p_early_edge; $rose(early_pair_detect) |-> in_band; endproperty
   property p_early_loss; stale |-> !early_pair_detect; endproperty
   property p_seg; s_seg_step |=> $stable(col_sample) [*8]; endproperty
   property p_mix;
      ($stable(row_sample) && $stable(col_sample)) [*2] |->
         tone_mix == {1'h0, row_sample} + {1'h0, col_sample};
   endproperty
   a_ok: assert property (p_ok)
      else $error("bus answer not ready or not okay");
   a_gt_oe: assert property (p_gt_oe)
      else $error("guard pin not driven");
   a_gt_follow: assert property (p_gt_follow)
      else $error("guard high without early detect");
   a_gt_steer: assert property (p_gt_steer)
      else $error("guard rose without steering");
   a_early_edge: assert property (p_early_edge)
      else $error("early detect rose without in-band tones");
   a_early_loss: assert property (p_early_loss)
      else $error("early detect held after tone loss");
   a_seg: assert property (p_seg)
      else $error("segment shorter than 9 cycles");
   a_mix: assert property (p_mix)
      else $error("mix is not row plus column");
endmodule
`default_nettype wire

// ### sim/dtc_tone_src.sv
/*
 * dtc_tone_src: limited tone pair source and steering RC network.
 * Assumes periods and guard time counted in system clock cycles.
 */
`default_nettype none
module dtc_tone_src #(
   parameter int GT_CYC = 200
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic tone_on,
   input wire logic [15:0] low_per,
   input wire logic [15:0] high_per,
   input wire logic early_pair_detect,
   input wire logic guard_time_drive,
   output logic low_tone_in,
   output logic high_tone_in,
   output logic steering_sense
);
   logic [15:0] lcnt, hcnt;
   int vc;
   // no signal leaves the limiters parked low
   assign low_tone_in = tone_on && lcnt < (low_per >> 1);
   assign high_tone_in = tone_on && hcnt < (high_per >> 1);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lcnt <= 16'h0000;
         hcnt <= 16'h0000;
         vc <= 0;
         steering_sense <= 1'h0;
      end else begin
         lcnt <= (!tone_on || lcnt == low_per - 16'h0001) ? 16'h0000 : lcnt + 16'h0001;
         hcnt <= (!tone_on || hcnt == high_per - 16'h0001) ? 16'h0000 : hcnt + 16'h0001;
         if (guard_time_drive) vc <= GT_CYC;
         else if (early_pair_detect) vc <= (vc < GT_CYC) ? vc + 1 : vc;
         else if (vc > 0) vc <= vc - 1;
         // hysteresis: short dropouts and short bursts never cross
         if (vc >= GT_CYC) steering_sense <= 1'h1;
         else if (vc == 0) steering_sense <= 1'h0;
      end
   end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
/*
 * tb_top: register-level test of dtc_tone_codec_core with a tone source.
 * Assumes the core answers AHB-Lite with zero wait states.
 */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dtc_pkg::*;
   logic clk_sys = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, progress_in = 1'h0;
   logic tone_on = 1'h0, cp_phase = 1'h0, saw_early = 1'h0;
   logic hreadyout, hresp, low_tone_in, high_tone_in, steering_sense;
   logic guard_time_drive, guard_time_oe, early_pair_detect;
   logic irq_or_progress_out, irq_or_progress_oe;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic [7:0] row_sample, col_sample;
   logic [8:0] tone_mix;
   int errors = 0, checks_done = 0, cyc = 0;

   dtc_tone_codec_core i_dtc_tone_codec_core (.hready(hreadyout), .*);
   dtc_tone_src i_dtc_tone_src (.low_per(16'(CLK_HZ / 941)), .high_per(16'(CLK_HZ / 1477)), .*);

   initial begin
      forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cp_phase && early_pair_detect) saw_early <= 1'h1;
      if (cyc == 90000) begin
         errors++;
         $display("MISMATCH t=%0t run hung", $time);
         close_out();
      end
   end

   task automatic close_out();
      $display("errors=%0d checks=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen %0h want %0h", $time, seen, exp);
      end
   endtask

   task automatic xfer(input logic wr, input logic [31:0] idx, input logic [3:0] d);
      @(posedge clk_sys);
      hsel <= 1'h1;
      haddr <= idx << 2;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {28'h000_0000, d};
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask

   // one row or column period, timed between rising mid-scale crossings
   task automatic measure_tone(input logic grp, input int f);
      int seg, t0, d;
      logic [7:0] pv, cv;
      real want;
      seg = (OSC_HZ + 16 * f) / (32 * f);
      want = 32.0 * seg * CLK_HZ / OSC_HZ;
      t0 = -1;
      d = 0;
      pv = grp ? col_sample : row_sample;
      while (d == 0) begin
         @(posedge clk_sys);
         cv = grp ? col_sample : row_sample;
         if (pv < 8'h80 && cv >= 8'h80) begin
            if (t0 >= 0) d = cyc - t0;
            t0 = cyc;
         end
         pv = cv;
      end
      chk(32'(d > want - 4.0 && d < want + 4.0), 1'h1);
   endtask

   task automatic cp_check();
      for (int i = 0; i < 4; i++) begin
         progress_in <= i[0];
         repeat (6) @(posedge clk_sys);
         chk(irq_or_progress_oe, !i[0]);
      end
      // long enough for two low-group periods
      repeat (23000) @(posedge clk_sys);
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'h0;
      chk(row_sample, 8'h80);
      chk(tone_mix, 9'h100);
      xfer(1'h0, CTRL_IDX, 4'h0);
      chk(rd, 4'h0);
      xfer(1'h0, DATA_IDX, 4'h0);
      chk(rd, 4'h0);
      xfer(1'h1, 32'h0000_0002, 4'hf);
      xfer(1'h0, 32'h0000_0002, 4'h0);
      chk(rd, 4'h0);
      xfer(1'h1, DATA_IDX, 4'hc);
      xfer(1'h1, CTRL_IDX, 4'h7);
      cp_phase <= 1'h1;
      tone_on <= 1'h1;
      fork
         measure_tone(1'h1, 1477);
         measure_tone(1'h0, 941);
         cp_check();
      join
      cp_phase <= 1'h0;
      chk(saw_early, 1'h0);
      xfer(1'h1, CTRL_IDX, 4'h5);
      while (irq_or_progress_oe !== 1'h1) @(posedge clk_sys);
      chk(early_pair_detect, 1'h1);
      chk(guard_time_drive, 1'h1);
      chk(irq_or_progress_out, 1'h0);
      xfer(1'h0, DATA_IDX, 4'h0);
      chk(rd, 4'hc);
      xfer(1'h0, CTRL_IDX, 4'h0);
      chk(rd, 4'hd);
      xfer(1'h0, CTRL_IDX, 4'h0);
      chk(rd, 4'h8);
      chk(irq_or_progress_oe, 1'h0);
      tone_on <= 1'h0;
      repeat (LOSS_CYC_DEF + 1000) @(posedge clk_sys);
      chk(early_pair_detect, 1'h0);
      chk(guard_time_drive, 1'h0);
      xfer(1'h0, CTRL_IDX, 4'h0);
      chk(rd, 4'h0);
      xfer(1'h0, DATA_IDX, 4'h0);
      chk(rd, 4'hc);
      close_out();
   end
endmodule

bind dtc_tone_codec_core dtc_core_props #(.LOSS_CYC(LOSS_CYC)) i_dtc_core_props (.*);
`default_nettype wire
